// ---- design/txsel_top.sv ----
// Source selection for both antenna driver inputs and the serial signal-out pin.
// Assumes one 250 MHz clock, a synchronous active-low reset and an AXI4-Lite master.
//
// Behaviour
// - Driver select 00 floats both driver inputs, 11 holds them high.
// - Driver select 01 feeds coder envelope, 10 feeds serial input pin envelope.
// - Soft power-down floats drivers only when driver select holds the float code.
// - Constant high driver level follows each driver's inversion settings.
// - Signal-out select 0000 floats pin, 0001 drives low, 0010 drives high.
// - Signal-out select 0011 routes the chosen internal test line.
// - Signal-out 0100 gives coder envelope, 0101 gives serial stream to transmit.
// - Signal-out 0110 gives regenerated delayed card modulation for three-wire module.
// - Signal-out 0111 gives received serial stream; avoid in card mode.
// - Source select bits 7 to 6 read zero; six low bits are read-write.
// - Source select register at 16h resets to 10h.
// - Driver output inverts per enabled-state or disabled-state inversion bit.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "txsel_cfg.svh"
`default_nettype none

// ==========================================================================
// Buffer
// ==========================================================================
module txsel_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic in_ready_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [AW:0] count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);

	// Ready is registered from the next count, so the stream port leaves a flip-flop.
	assign in_ready = in_ready_r;
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];
	assign level = count_r;

	always_ff @(posedge aclk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			in_ready_r <= 1'b1;
		end else begin
			wr_ptr_r <= push ? wr_ptr_r + AW'(1) : wr_ptr_r;
			rd_ptr_r <= pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
			count_r <= count_nxt;
			in_ready_r <= (count_nxt != (AW+1)'(DEPTH));
		end
	end
endmodule

// ==========================================================================
// Selector
// ==========================================================================
module txsel_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic coder_envelope,
	input wire logic serial_signal_in_pin,
	input wire logic [7:0] internal_test_lines,
	input wire logic [2:0] test_bus_line_select,
	input wire logic rx_card_modulation,
	input wire logic rx_serial_data,
	input wire logic tx_bit_valid,
	input wire logic tx_bit_data,
	output logic tx_bit_ready,
	input wire logic tx_bit_tick,
	input wire logic drv1_enabled,
	input wire logic drv2_enabled,
	input wire logic invert_drv1_when_on,
	input wire logic invert_drv1_when_off,
	input wire logic invert_drv2_when_on,
	input wire logic invert_drv2_when_off,
	output txsel_pkg::txsel_pin_type antenna_driver_one,
	output txsel_pkg::txsel_pin_type antenna_driver_two,
	output txsel_pkg::txsel_pin_type serial_signal_out_pin
);
	// ======================================================================
	// Register bus state
	// ======================================================================
	logic [5:0] tx_source_select_r;
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic tx_bit_r;
	txsel_pkg::txsel_pin_type drv_pin_r [2];
	txsel_pkg::txsel_pin_type sig_pin_r;

	function automatic logic drv_invert(input logic enabled, input logic inv_on,
		input logic inv_off);
		drv_invert = enabled ? inv_on : inv_off;
	endfunction

	wire aw_take = s_axi_awvalid && !aw_held_r && !bvalid_r;
	wire w_take = s_axi_wvalid && !w_held_r && !bvalid_r;
	wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
	wire wr_hit = (aw_addr_r == `TXSEL_ADDR_SOURCE_SELECT);
	wire wr_status = (aw_addr_r == `TXSEL_ADDR_STATUS);
	wire ar_take = s_axi_arvalid && !rvalid_r;
	wire rd_hit = (s_axi_araddr == `TXSEL_ADDR_SOURCE_SELECT);
	wire rd_status = (s_axi_araddr == `TXSEL_ADDR_STATUS);

	// ======================================================================
	// Transmit stream buffer
	// ======================================================================
	wire fifo_out_valid;
	wire [0:0] fifo_out_data;
	wire [4:0] fifo_level;
	wire fifo_pop = fifo_out_valid && tx_bit_tick;

	txsel_fifo #(
		.WIDTH(`TXSEL_FIFO_WIDTH),
		.DEPTH(`TXSEL_FIFO_DEPTH)
	) u_fifo (
		.aclk(aclk),
		.aresetn(aresetn),
		.in_valid(tx_bit_valid),
		.in_data(tx_bit_data),
		.in_ready(tx_bit_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(tx_bit_tick),
		.level(fifo_level)
	);

	// ======================================================================
	// Selection
	// ======================================================================
	txsel_pkg::txsel_drv_sel_type drv_sel;
	txsel_pkg::txsel_sig_sel_type sig_sel;
	assign drv_sel = txsel_pkg::txsel_drv_sel_type'(
		tx_source_select_r[`TXSEL_DRV_SEL_HI:`TXSEL_DRV_SEL_LO]);
	assign sig_sel = txsel_pkg::txsel_sig_sel_type'(
		tx_source_select_r[`TXSEL_SIG_SEL_HI:`TXSEL_SIG_SEL_LO]);

	wire [1:0] drv_en = {drv2_enabled, drv1_enabled};
	wire [1:0] inv_on = {invert_drv2_when_on, invert_drv1_when_on};
	wire [1:0] inv_off = {invert_drv2_when_off, invert_drv1_when_off};
	logic drv_src;
	txsel_pkg::txsel_pin_type sig_nxt;

	always_comb begin
		unique case (drv_sel)
			txsel_pkg::TXSEL_DRV_TRISTATE: drv_src = 1'b0;
			txsel_pkg::TXSEL_DRV_CODER: drv_src = coder_envelope;
			txsel_pkg::TXSEL_DRV_SERIAL_SIGNAL_IN_PIN: drv_src = serial_signal_in_pin;
			txsel_pkg::TXSEL_DRV_HIGH: drv_src = 1'b1;
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_drv
			txsel_pkg::txsel_pin_type drv_nxt;
			wire drv_oe;
			wire drv_lvl;
			// Power-down has no term here: only the float code floats the drivers.
			assign drv_oe = (drv_sel != txsel_pkg::TXSEL_DRV_TRISTATE);
			assign drv_lvl = drv_oe &&
				(drv_src ^ drv_invert(drv_en[gi], inv_on[gi], inv_off[gi]));
			assign drv_nxt = '{level: drv_lvl, oe: drv_oe};
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					drv_pin_r[gi] <= '0;
				end else begin
					drv_pin_r[gi] <= drv_nxt;
				end
			end
		end
	endgenerate

	always_comb begin
		sig_nxt = '0;
		unique case (sig_sel)
			txsel_pkg::TXSEL_SIG_TRISTATE: sig_nxt = '0;
			txsel_pkg::TXSEL_SIG_LOW: sig_nxt = '{level: 1'b0, oe: 1'b1};
			txsel_pkg::TXSEL_SIG_HIGH: sig_nxt = '{level: 1'b1, oe: 1'b1};
			txsel_pkg::TXSEL_SIG_TEST_BUS:
				sig_nxt = '{level: internal_test_lines[test_bus_line_select], oe: 1'b1};
			txsel_pkg::TXSEL_SIG_CODER: sig_nxt = '{level: coder_envelope, oe: 1'b1};
			txsel_pkg::TXSEL_SIG_TX_STREAM: sig_nxt = '{level: tx_bit_r, oe: 1'b1};
			txsel_pkg::TXSEL_SIG_RX_MOD:
				sig_nxt = '{level: rx_card_modulation, oe: 1'b1};
			txsel_pkg::TXSEL_SIG_RX_STREAM: sig_nxt = '{level: rx_serial_data, oe: 1'b1};
			default: sig_nxt = '0;
		endcase
	end

	// ======================================================================
	// Pin and stream registers
	// ======================================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sig_pin_r <= '0;
			tx_bit_r <= 1'b0;
		end else begin
			sig_pin_r <= sig_nxt;
			tx_bit_r <= fifo_pop ? fifo_out_data[0] : tx_bit_r;
		end
	end

	assign antenna_driver_one = drv_pin_r[0];
	assign antenna_driver_two = drv_pin_r[1];
	assign serial_signal_out_pin = sig_pin_r;

	// ======================================================================
	// AXI4-Lite write path
	// ======================================================================
	// Address and data are held separately so either may arrive first.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
			bvalid_r <= 1'b0;
			bresp_r <= `TXSEL_RESP_OKAY;
			tx_source_select_r <= 6'(`TXSEL_SOURCE_SELECT_RESET);
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (wr_hit || wr_status) ? `TXSEL_RESP_OKAY : `TXSEL_RESP_SLVERR;
				if (wr_hit && w_strb_r[0]) begin
					tx_source_select_r <= 6'(w_data_r[7:0] & `TXSEL_SOURCE_SELECT_WMASK);
				end
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ======================================================================
	// AXI4-Lite read path
	// ======================================================================
	wire [31:0] rd_word = rd_hit ? {26'h0, tx_source_select_r} :
		rd_status ? {22'h0, fifo_level, tx_bit_r, sig_pin_r, drv_pin_r[1].oe,
		drv_pin_r[0].oe} : 32'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= `TXSEL_RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_word;
			rresp_r <= (rd_hit || rd_status) ? `TXSEL_RESP_OKAY : `TXSEL_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ======================================================================
	// Handshake readiness
	// ======================================================================
	// The readies are registered from the next channel state; the take terms above
	// read the state flops, which always agree with these registered copies.
	wire aw_held_nxt = wr_fire ? 1'b0 : (aw_take || aw_held_r);
	wire w_held_nxt = wr_fire ? 1'b0 : (w_take || w_held_r);
	wire bvalid_nxt = wr_fire || (bvalid_r && !s_axi_bready);
	wire rvalid_nxt = ar_take || (rvalid_r && !s_axi_rready);
	logic awready_r;
	logic wready_r;
	logic arready_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
		end else begin
			awready_r <= !aw_held_nxt && !bvalid_nxt;
			wready_r <= !w_held_nxt && !bvalid_nxt;
			arready_r <= !rvalid_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
endmodule

`default_nettype wire

// ---- design/txsel_cfg.svh ----
// Offsets, field positions and reset values for the transmit source selector.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef TXSEL_CFG_SVH
`define TXSEL_CFG_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define TXSEL_ADDR_W 8
`define TXSEL_IDX_SOURCE_SELECT 8'h16
`define TXSEL_IDX_STATUS 8'h20
`define TXSEL_ADDR_SOURCE_SELECT 8'h58
`define TXSEL_ADDR_STATUS 8'h80
`define TXSEL_SOURCE_SELECT_RESET 8'h10
`define TXSEL_SOURCE_SELECT_WMASK 8'h3f

// ==========================================================================
// Fields
// ==========================================================================
`define TXSEL_DRV_SEL_HI 5
`define TXSEL_DRV_SEL_LO 4
`define TXSEL_SIG_SEL_HI 3
`define TXSEL_SIG_SEL_LO 0

// ==========================================================================
// Buffer and bus answers
// ==========================================================================
`define TXSEL_FIFO_DEPTH 16
`define TXSEL_FIFO_WIDTH 1
`define TXSEL_RESP_OKAY 2'h0
`define TXSEL_RESP_SLVERR 2'h2

`endif

// ---- design/txsel_pkg.sv ----
// Types shared by the transmit source selector.
// Assumes txsel_cfg.svh is compiled alongside.
package txsel_pkg;

	// ======================================================================
	// Selection codes
	// ======================================================================
	typedef enum logic [1:0] {
		TXSEL_DRV_TRISTATE = 2'h0,
		TXSEL_DRV_CODER = 2'h1,
		TXSEL_DRV_SERIAL_SIGNAL_IN_PIN = 2'h2,
		TXSEL_DRV_HIGH = 2'h3
	} txsel_drv_sel_type;

	typedef enum logic [3:0] {
		TXSEL_SIG_TRISTATE = 4'h0,
		TXSEL_SIG_LOW = 4'h1,
		TXSEL_SIG_HIGH = 4'h2,
		TXSEL_SIG_TEST_BUS = 4'h3,
		TXSEL_SIG_CODER = 4'h4,
		TXSEL_SIG_TX_STREAM = 4'h5,
		TXSEL_SIG_RX_MOD = 4'h6,
		TXSEL_SIG_RX_STREAM = 4'h7
	} txsel_sig_sel_type;

	// ======================================================================
	// Pin carrier
	// ======================================================================
	typedef struct packed {
		logic level;
		logic oe;
	} txsel_pin_type;

endpackage

// ---- tb/txsel_top_properties.sv ----
// Concurrent checks on the ports of txsel_top.
// Assumes one aclk domain with a synchronous active-low aresetn.
`timescale 1ns/1ns
`default_nettype none
module txsel_top_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic coder_envelope,
	input wire logic tx_bit_ready,
	input wire logic drv1_enabled,
	input wire logic drv2_enabled,
	input wire logic invert_drv1_when_on,
	input wire logic invert_drv1_when_off,
	input wire logic invert_drv2_when_on,
	input wire logic invert_drv2_when_off,
	input wire txsel_pkg::txsel_pin_type antenna_driver_one,
	input wire txsel_pkg::txsel_pin_type antenna_driver_two,
	input wire txsel_pkg::txsel_pin_type serial_signal_out_pin
);
	// ====
	// Checks
	// ====
	// Both drivers share one source, so their levels must agree once each inversion is undone.
	wire inv1 = drv1_enabled ? invert_drv1_when_on : invert_drv1_when_off;
	wire inv2 = drv2_enabled ? invert_drv2_when_on : invert_drv2_when_off;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_drv_oe_pair: assert property (antenna_driver_one.oe == antenna_driver_two.oe)
		else $error("driver enables differ");
	chk_float_quiet: assert property (!antenna_driver_one.oe |-> !antenna_driver_one.level)
		else $error("floating driver not low");
	chk_sig_float: assert property (!serial_signal_out_pin.oe |-> !serial_signal_out_pin.level)
		else $error("floating signal out not low");
	chk_inv_pair: assert property (antenna_driver_one.oe |-> (antenna_driver_one.level ^ $past(inv1))
		== (antenna_driver_two.level ^ $past(inv2)))
		else $error("driver inversion mismatch");
	chk_reset_default: assert property ($rose(aresetn) |=> antenna_driver_one.oe
		&& !serial_signal_out_pin.oe && antenna_driver_one.level == $past(coder_envelope ^ inv1))
		else $error("pins wrong after reset");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read data not zero");
	cover property (antenna_driver_one.oe && antenna_driver_one.level);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	cover property (!tx_bit_ready);
endmodule
`default_nettype wire

// ---- tb/txsel_sam_model.sv ----
// Serial-side partner: drives the external envelope into the selector.
// Assumes aclk and aresetn of the bench; the line only moves while run is high.
`timescale 1ns/1ns
`default_nettype none
module txsel_sam_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire txsel_pkg::txsel_pin_type sig_out,
	output logic sig_in
);
	logic [7:0] pat_r;
	// A rotating pattern changes level often enough to catch a stale driver source.
	always_ff @(posedge aclk) begin
		if (!aresetn)
			pat_r <= 8'hb5;
		else if (run)
			pat_r <= {pat_r[0], pat_r[7:1]};
	end
	assign sig_in = pat_r[0];
endmodule
`default_nettype wire

// ---- tb/tx_driver_serial_signal_out_pin_source_select_test.sv ----
// Self-checking bench for txsel_top with the serial-side partner model.
// Assumes txsel_cfg.svh is on the include path and the package is compiled first.
`timescale 1ns/1ns
`include "txsel_cfg.svh"
`default_nettype none
module tx_driver_serial_signal_out_pin_source_select_test;
	// ====
	// Signals
	// ====
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, coder_envelope = 1'h0;
	logic tx_bit_valid = 1'h0, tx_bit_data = 1'h0, tx_bit_tick = 1'h0, run = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, misc = 8'h9e;
	logic [7:0] internal_test_lines = 8'h5a;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, test_bus_line_select = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, tx_bit_ready;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	wire drv1_enabled, drv2_enabled, invert_drv1_when_on, invert_drv1_when_off;
	wire invert_drv2_when_on, invert_drv2_when_off, rx_card_modulation, rx_serial_data;
	wire serial_signal_in_pin;
	txsel_pkg::txsel_pin_type antenna_driver_one, antenna_driver_two, serial_signal_out_pin;
	logic [15:0] pat = 16'hb4c3;
	int n_errors = 0;
	int samples_checked = 0;
	// Row: select byte, side inputs, {coder, test line}, expected {driver one, two, signal out}.
	// Receiver is held in receiving mode, reader rather than card protocol.
	logic [25:0] rows [13] = '{
		{8'h11, 8'h9e, 4'h0, 6'h1d}, {8'h22, 8'h9e, 4'h8, 6'h37}, {8'h33, 8'h9e, 4'h2, 6'h35},
		{8'h13, 8'h9e, 4'h1, 6'h1f}, {8'h14, 8'h9e, 4'h8, 6'h37}, {8'h05, 8'h9e, 4'h0, 6'h01},
		{8'h16, 8'h9e, 4'h0, 6'h1f}, {8'h17, 8'h9e, 4'h0, 6'h1d}, {8'h16, 8'h51, 4'h0, 6'h35},
		{8'h17, 8'h51, 4'h8, 6'h1f}, {8'hff, 8'h51, 4'h0, 6'h1c}, {8'h08, 8'h9e, 4'h0, 6'h00},
		{8'h00, 8'h9e, 4'h0, 6'h00}};
	assign {drv1_enabled, drv2_enabled, invert_drv1_when_on, invert_drv1_when_off,
		invert_drv2_when_on, invert_drv2_when_off, rx_card_modulation, rx_serial_data} = misc;
	always #2 aclk = ~aclk;
	txsel_top i_dut (.*);
	txsel_sam_model i_sam (.aclk(aclk), .aresetn(aresetn), .run(run),
		.sig_out(serial_signal_out_pin), .sig_in(serial_signal_in_pin));
	// ====
	// Tasks
	// ====
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic end_of_test;
		$display("Checks made %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ====
	// Sequence
	// ====
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		axr(`TXSEL_ADDR_SOURCE_SELECT);
		chk(d, {24'h0, `TXSEL_SOURCE_SELECT_RESET});
		foreach (rows[i]) begin
			@(posedge aclk);
			misc <= rows[i][17:10];
			{coder_envelope, test_bus_line_select} <= rows[i][9:6];
			axw(`TXSEL_ADDR_SOURCE_SELECT, {24'h0, rows[i][25:18]});
			repeat (2) @(posedge aclk);
			chk({antenna_driver_one, antenna_driver_two, serial_signal_out_pin}, rows[i][5:0]);
			axr(`TXSEL_ADDR_SOURCE_SELECT);
			chk(d, {24'h0, rows[i][25:18] & 8'h3f});
		end
		axw(`TXSEL_ADDR_SOURCE_SELECT, 32'h20);
		run <= 1'h1;
		@(posedge aclk);
		for (int i = 0; i < 12; i++) begin
			d[0] = serial_signal_in_pin;
			@(posedge aclk);
			chk({31'h0, antenna_driver_one.level}, {31'h0, d[0]});
		end
		run <= 1'h0;
		axw(`TXSEL_ADDR_SOURCE_SELECT, 32'h05);
		tx_bit_valid <= 1'h1;
		for (int i = 0; i < 16; i++) begin
			tx_bit_data <= pat[i];
			do @(posedge aclk); while (!tx_bit_ready);
		end
		repeat (3) @(posedge aclk);
		tx_bit_valid <= 1'h0;
		chk({31'h0, tx_bit_ready}, 32'h0);
		axr(`TXSEL_ADDR_STATUS);
		chk({27'h0, d[9:5]}, 32'h10);
		for (int i = 0; i < 16; i++) begin
			tx_bit_tick <= 1'h1;
			@(posedge aclk);
			tx_bit_tick <= 1'h0;
			repeat (2) @(posedge aclk);
			chk({31'h0, serial_signal_out_pin.level}, {31'h0, pat[i]});
		end
		axr(`TXSEL_ADDR_STATUS);
		chk({27'h0, d[9:5]}, 32'h0);
		axr(8'h04);
		chk({d[29:0], resp}, {30'h0, `TXSEL_RESP_SLVERR});
		axw(8'h04, 32'h3f);
		chk({30'h0, resp}, {30'h0, `TXSEL_RESP_SLVERR});
		aresetn <= 1'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		axr(`TXSEL_ADDR_SOURCE_SELECT);
		chk(d, {24'h0, `TXSEL_SOURCE_SELECT_RESET});
		chk({30'h0, antenna_driver_one.oe, serial_signal_out_pin.oe}, 32'h2);
		s_axi_wstrb <= 4'h0;
		axw(`TXSEL_ADDR_SOURCE_SELECT, 32'h3f);
		axr(`TXSEL_ADDR_SOURCE_SELECT);
		chk({d[29:0], resp}, {22'h0, `TXSEL_SOURCE_SELECT_RESET, `TXSEL_RESP_OKAY});
		end_of_test();
	end
endmodule
bind txsel_top txsel_top_props i_props (.*);
`default_nettype wire
